// ---- logic/oscillator_mode_control.sv ----
// Oscillator selection, operating modes and clock release with an APB register port
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module oscillator_mode_control (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [osc_mode_pkg::addr_width-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [osc_mode_pkg::data_width-1:0] pwdata,
	output logic [osc_mode_pkg::data_width-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] high_clock_option,
	input wire logic watchdog_always_on,
	input wire logic watchdog_enable,
	input wire logic [2:0] fcpu_divide_code,
	input wire logic high_clock_tick,
	input wire logic port_wake,
	input wire logic timer_wake,
	output logic internal_fast_rc_osc_enable,
	output logic external_osc_enable,
	output logic rtc_crystal_enable,
	output logic internal_slow_rc_osc_enable,
	output logic system_clock_slow,
	output logic cpu_clock_release,
	output logic [2:0] fcpu_divide_log2,
	output logic crystal_in_pin_gpio,
	output logic crystal_out_pin_gpio
);
	import osc_mode_pkg::*;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic uses_fast_rc(input logic [2:0] opt);
		uses_fast_rc = (opt == opt_fast_rc_only) || (opt == opt_fast_rc_rtc);
	endfunction

	function automatic logic uses_crystal(input logic [2:0] opt);
		uses_crystal = (opt == opt_fast_rc_rtc) || (opt == opt_crystal_32k)
			|| (opt == opt_crystal_12m) || (opt == opt_crystal_4m);
	endfunction

	function automatic logic uses_ext_osc(input logic [2:0] opt);
		uses_ext_osc = (opt == opt_ext_rc) || (opt == opt_crystal_32k)
			|| (opt == opt_crystal_12m) || (opt == opt_crystal_4m);
	endfunction

	function automatic logic [2:0] legal_option(input logic [2:0] opt);
		if (opt > opt_crystal_4m) begin
			legal_option = opt_fast_rc_only;
		end else begin
			legal_option = opt;
		end
	endfunction

	function automatic logic reg_hit(input logic [addr_width-1:0] addr,
		input logic [9:0] index);
		reg_hit = (addr[addr_width-1:2] == index) && (addr[1:0] == 2'h0);
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		mode_state_t state;
		logic [1:0] settle;
		logic [2:0] option;
		logic always_on;
		logic wdt_on;
		logic [2:0] div_code;
		logic stop_fast_clock;
		logic slow_clock_select;
		logic [1:0] cpu_power_mode;
		logic tick_last;
		logic wake_last;
		logic warm_start;
		logic [11:0] warm_periods;
		logic ready;
		logic err;
		logic [data_width-1:0] rdata;
		logic fast_rc_en;
		logic ext_en;
		logic rtc_en;
		logic slow_rc_en;
		logic sys_slow;
		logic release_clk;
		logic [2:0] div_log2;
		logic in_gpio;
		logic out_gpio;
	} ctrl_state_t;

	ctrl_state_t cur;
	ctrl_state_t next_cur;
	logic [sync_width-1:0] pins_sync;
	logic warm_done;
	logic tick_now;
	logic wake_now;
	logic tick_edge;
	logic wake_edge;
	logic access;
	logic do_write;
	logic hit_control;
	logic hit_status;
	logic [7:0] control_value;
	logic [7:0] status_value;

	// ************************************************************
	// Pin synchronisers and warm-up counter
	// ************************************************************
	level_sync pin_sync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.async_in({high_clock_option, watchdog_always_on, watchdog_enable,
			fcpu_divide_code, high_clock_tick, port_wake}),
		.sync_out(pins_sync)
	);

	warm_up_counter warm_count (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.start(cur.warm_start),
		.periods(cur.warm_periods),
		.period_tick(tick_edge),
		.done(warm_done)
	);

	assign tick_now = pins_sync[1];
	assign wake_now = pins_sync[0];
	assign tick_edge = tick_now && !cur.tick_last;
	assign wake_edge = wake_now != cur.wake_last;

	// ************************************************************
	// Register decode
	// ************************************************************
	assign access = psel && penable && !cur.ready;
	assign hit_control = reg_hit(paddr, control_index);
	assign hit_status = reg_hit(paddr, status_index);
	assign do_write = access && pwrite && hit_control;
	assign control_value = {3'h0, cur.cpu_power_mode, cur.slow_clock_select,
		cur.stop_fast_clock, 1'b0};
	assign status_value = {cur.sys_slow, cur.slow_rc_en, cur.rtc_en, cur.ext_en,
		cur.fast_rc_en, cur.state[1:0] == 2'h3 ? cur.state[2] : 1'b0, 1'b0,
		cur.release_clk};

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_cur = cur;
		next_cur.tick_last = tick_now;
		next_cur.wake_last = wake_now;
		next_cur.warm_start = 1'b0;
		next_cur.ready = access;
		next_cur.err = 1'b0;

		unique case (cur.state)
			st_capture: begin
				// Straps settle through the synchroniser, then freeze
				if (cur.settle == settle_cycles) begin
					next_cur.option = legal_option(pins_sync[9:7]);
					next_cur.always_on = pins_sync[6];
					next_cur.wdt_on = pins_sync[5];
					next_cur.div_code = pins_sync[4:2];
					next_cur.warm_periods = warm_reset_periods;
					next_cur.warm_start = 1'b1;
					next_cur.state = st_warm_up;
				end else begin
					next_cur.settle = cur.settle + 2'h1;
				end
			end
			st_warm_up: begin
				if (warm_done && !cur.warm_start) begin
					next_cur.state = st_run;
				end
			end
			st_run: begin
				if (cur.cpu_power_mode == mode_sleep) begin
					next_cur.state = st_sleep;
				end else if (cur.cpu_power_mode == mode_green) begin
					next_cur.state = st_green;
				end
			end
			st_green: begin
				if (wake_edge || timer_wake) begin
					next_cur.cpu_power_mode = mode_normal;
					next_cur.state = st_run;
				end
			end
			st_sleep: begin
				if (wake_edge) begin
					next_cur.cpu_power_mode = mode_normal;
					next_cur.slow_clock_select = 1'b0;
					next_cur.warm_start = 1'b1;
					if (uses_crystal(cur.option)) begin
						next_cur.warm_periods = warm_crystal_periods;
					end else begin
						next_cur.warm_periods = warm_rc_periods;
					end
					next_cur.state = st_warm_up;
				end
			end
			default: begin
				next_cur.state = st_capture;
			end
		endcase

		// Software write lands after hardware clears, so a set is never lost
		if (do_write) begin
			next_cur.stop_fast_clock = pwdata[stop_bit];
			next_cur.slow_clock_select = pwdata[slow_bit];
			next_cur.cpu_power_mode = pwdata[mode_msb:mode_lsb];
		end

		// APB answer one cycle into the access phase
		if (access) begin
			if (hit_control) begin
				next_cur.rdata = {24'h000000, control_value & control_write_mask};
			end else if (hit_status && !pwrite) begin
				next_cur.rdata = {24'h000000, status_value};
			end else begin
				next_cur.rdata = '0;
				next_cur.err = 1'b1;
			end
		end

		// Oscillator enables
		next_cur.fast_rc_en = uses_fast_rc(cur.option) && !cur.stop_fast_clock
			&& (cur.state != st_sleep);
		next_cur.ext_en = uses_ext_osc(cur.option) && !cur.stop_fast_clock
			&& (cur.state != st_sleep);
		next_cur.rtc_en = (cur.option == opt_fast_rc_rtc) && !cur.stop_fast_clock
			&& (cur.state != st_sleep);
		next_cur.slow_rc_en = !((cur.state == st_sleep)
			|| ((cur.state == st_green)
			&& (((cur.option == opt_fast_rc_rtc) && !cur.always_on)
			|| ((cur.option == opt_crystal_32k) && !cur.wdt_on))));

		// System clock source and instruction divider
		next_cur.sys_slow = cur.slow_clock_select;
		if (cur.slow_clock_select) begin
			next_cur.div_log2 = div_log2_slow;
		end else if (cur.div_code > div_log2_max) begin
			next_cur.div_log2 = div_log2_max;
		end else if (uses_fast_rc(cur.option) && (cur.div_code < div_log2_min_rc)) begin
			next_cur.div_log2 = div_log2_min_rc;
		end else begin
			next_cur.div_log2 = cur.div_code;
		end

		// Clock only after warm-up, and never with no running source
		next_cur.release_clk = (cur.state == st_run) && (cur.cpu_power_mode == mode_normal)
			&& !(cur.stop_fast_clock && !cur.slow_clock_select);

		// Crystal pin ownership
		next_cur.in_gpio = (cur.option == opt_fast_rc_only);
		next_cur.out_gpio = (cur.option == opt_fast_rc_only)
			|| (cur.option == opt_ext_rc);
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
			cur.state <= st_capture;
			cur.slow_rc_en <= 1'b1;
			cur.in_gpio <= 1'b1;
			cur.out_gpio <= 1'b1;
			cur.stop_fast_clock <= control_reset[stop_bit];
			cur.slow_clock_select <= control_reset[slow_bit];
			cur.cpu_power_mode <= control_reset[mode_msb:mode_lsb];
		end else begin
			cur <= next_cur;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign prdata = cur.rdata;
	assign pready = cur.ready;
	assign pslverr = cur.err;
	assign internal_fast_rc_osc_enable = cur.fast_rc_en;
	assign external_osc_enable = cur.ext_en;
	assign rtc_crystal_enable = cur.rtc_en;
	assign internal_slow_rc_osc_enable = cur.slow_rc_en;
	assign system_clock_slow = cur.sys_slow;
	assign cpu_clock_release = cur.release_clk;
	assign fcpu_divide_log2 = cur.div_log2;
	assign crystal_in_pin_gpio = cur.in_gpio;
	assign crystal_out_pin_gpio = cur.out_gpio;
endmodule
`default_nettype wire

// ---- shared/osc_mode_pkg.sv ----
// Constants and types shared by the oscillator and operating-mode control block
// ****************************************************************************
// ****************************************************************************
package osc_mode_pkg;
	localparam int addr_width = 12;
	localparam int data_width = 32;
	localparam logic [9:0] control_index = 10'h0CA;
	localparam logic [9:0] status_index = 10'h0CB;
	localparam logic [7:0] control_reset = 8'h00;
	localparam logic [7:0] control_write_mask = 8'h1E;
	localparam int stop_bit = 1;
	localparam int slow_bit = 2;
	localparam int mode_lsb = 3;
	localparam int mode_msb = 4;
	localparam logic [1:0] mode_normal = 2'h0;
	localparam logic [1:0] mode_sleep = 2'h1;
	localparam logic [1:0] mode_green = 2'h2;
	localparam logic [2:0] opt_fast_rc_only = 3'h0;
	localparam logic [2:0] opt_fast_rc_rtc = 3'h1;
	localparam logic [2:0] opt_ext_rc = 3'h2;
	localparam logic [2:0] opt_crystal_32k = 3'h3;
	localparam logic [2:0] opt_crystal_12m = 3'h4;
	localparam logic [2:0] opt_crystal_4m = 3'h5;
	localparam int warm_width = 12;
	localparam logic [11:0] warm_reset_periods = 12'h800;
	localparam logic [11:0] warm_crystal_periods = 12'h800;
	localparam logic [11:0] warm_rc_periods = 12'h020;
	localparam logic [2:0] div_log2_min_rc = 3'h2;
	localparam logic [2:0] div_log2_max = 3'h4;
	localparam logic [2:0] div_log2_slow = 3'h2;
	localparam logic [1:0] settle_cycles = 2'h3;
	localparam int sync_width = 10;
	typedef enum logic [2:0] {
		st_capture = 3'b000,
		st_warm_up = 3'b001,
		st_run = 3'b011,
		st_green = 3'b111,
		st_sleep = 3'b110
	} mode_state_t;
endpackage

// ---- logic/level_sync.sv ----
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module level_sync (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [osc_mode_pkg::sync_width-1:0] async_in,
	output logic [osc_mode_pkg::sync_width-1:0] sync_out
);
	import osc_mode_pkg::*;
	typedef struct packed {
		logic [sync_width-1:0] first;
		logic [sync_width-1:0] second;
	} sync_state_t;
	sync_state_t cur;
	sync_state_t next_cur;
	always_comb begin
		next_cur.first = async_in;
		next_cur.second = cur.first;
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end
	assign sync_out = cur.second;
endmodule
`default_nettype wire

// ---- logic/warm_up_counter.sv ----
// Counts high-clock periods after a start request and flags completion
`timescale 1ns/10ps
`default_nettype none
module warm_up_counter (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [osc_mode_pkg::warm_width-1:0] periods,
	input wire logic period_tick,
	output logic done
);
	import osc_mode_pkg::*;
	typedef struct packed {
		logic [warm_width-1:0] remain;
		logic done;
	} warm_state_t;
	warm_state_t cur;
	warm_state_t next_cur;
	always_comb begin
		next_cur = cur;
		if (start) begin
			next_cur.remain = periods;
			next_cur.done = 1'b0;
		end else if (!cur.done && period_tick) begin
			next_cur.remain = cur.remain - 12'h001;
			next_cur.done = (cur.remain == 12'h001);
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end
	assign done = cur.done;
endmodule
`default_nettype wire

// ---- dv/osc_mode_asserts.sv ----
// Concurrent checks on the ports of the oscillator and mode control block
`timescale 1ns/10ps
`default_nettype none
module osc_mode_asserts (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [osc_mode_pkg::addr_width-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [osc_mode_pkg::data_width-1:0] pwdata,
	input wire logic pready,
	input wire logic [2:0] high_clock_option,
	input wire logic internal_fast_rc_osc_enable,
	input wire logic external_osc_enable,
	input wire logic internal_slow_rc_osc_enable,
	input wire logic system_clock_slow,
	input wire logic cpu_clock_release,
	input wire logic [2:0] fcpu_divide_log2,
	input wire logic crystal_in_pin_gpio,
	input wire logic crystal_out_pin_gpio
);
	import osc_mode_pkg::*;
	logic [15:0] since_rst;
	logic wr_ctl;
	logic run;
	assign wr_ctl = psel && penable && pready && pwrite && paddr == 12'h328;
	assign run = cpu_clock_release;
	// Cycles since reset, saturating
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) since_rst <= 16'h0000;
		else if (since_rst != 16'hFFFF) since_rst <= since_rst + 16'h0001;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_fast_only_pins: assert property (run && high_clock_option == 3'h0 |->
		crystal_in_pin_gpio && crystal_out_pin_gpio) else $error("pins not free");
	a_rtc_pins: assert property (run && high_clock_option == 3'h1 |->
		!crystal_in_pin_gpio && !crystal_out_pin_gpio) else $error("rtc pins free");
	a_ext_rc_pins: assert property (run && high_clock_option == 3'h2 |->
		!crystal_in_pin_gpio && crystal_out_pin_gpio) else $error("rc pins wrong");
	a_slow_divide: assert property (run && system_clock_slow |->
		fcpu_divide_log2 == 3'h2) else $error("slow divide wrong");
	a_rc_divide_range: assert property (run && high_clock_option < 3'h2 |->
		fcpu_divide_log2 inside {[3'h2:3'h4]}) else $error("divide out of range");
	a_slow_rc_run: assert property (run |-> internal_slow_rc_osc_enable)
		else $error("slow rc off while running");
	a_warm_up_hold: assert property (run |-> since_rst >= 16'h1000)
		else $error("clock released early");
	a_high_osc_runs: assert property (run && !system_clock_slow |->
		internal_fast_rc_osc_enable || external_osc_enable) else $error("no high clock");
	a_stop_fast: assert property (wr_ctl && pwdata[4:1] == 4'h3 && high_clock_option == 3'h0
		|-> ##[1:4] !internal_fast_rc_osc_enable) else $error("fast rc not stopped");
	a_slow_select: assert property (wr_ctl && pwdata[4:2] == 3'h1 |->
		##[1:4] system_clock_slow) else $error("slow clock not selected");
	a_apb_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("wait state wrong");
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
	cover property (wr_ctl && pwdata[4:3] == 2'h1);
	cover property (wr_ctl && pwdata[4:3] == 2'h2);
	cover property ($rose(cpu_clock_release));
endmodule
`default_nettype wire

// ---- dv/osc_partner.sv ----
// Oscillator stand-in giving one tick per high-clock period while enabled
`timescale 1ns/10ps
`default_nettype none
module osc_partner #(parameter int half_period = 2) (
	input wire logic sys_clk,
	input wire logic osc_on,
	output logic tick
);
	int phase = 0;
	initial tick = 1'b0;
	// Stopped oscillator holds its line low
	always @(posedge sys_clk) begin
		if (!osc_on) begin
			tick <= 1'b0;
			phase <= 0;
		end else if (phase == half_period - 1) begin
			tick <= !tick;
			phase <= 0;
		end else phase <= phase + 1;
	end
endmodule
`default_nettype wire

// ---- dv/test_oscillator_mode_control.sv ----
// Self-checking bench for the oscillator and mode control block
`timescale 1ns/10ps
`default_nettype none
module test_oscillator_mode_control;
	import osc_mode_pkg::*;
	logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic watchdog_always_on = 0, watchdog_enable = 0, port_wake = 0, timer_wake = 0;
	logic [addr_width-1:0] paddr = '0;
	logic [data_width-1:0] pwdata = '0, prdata;
	logic [2:0] high_clock_option = '0, fcpu_divide_code = '0, fcpu_divide_log2;
	logic pready, pslverr, high_clock_tick, internal_fast_rc_osc_enable, external_osc_enable;
	logic rtc_crystal_enable, internal_slow_rc_osc_enable, system_clock_slow, cpu_clock_release;
	logic crystal_in_pin_gpio, crystal_out_pin_gpio;
	int error_cnt = 0, total_checks = 0, cycles = 0, n, c;
	logic [31:0] seed = 32'h00007DF8, r;
	logic [33:0] notes[$], note;
	oscillator_mode_control u_oscillator_mode_control (.*);
	osc_partner u_osc_partner (.sys_clk(sys_clk), .tick(high_clock_tick),
		.osc_on(internal_fast_rc_osc_enable || external_osc_enable || rtc_crystal_enable));
	always #50 sys_clk = !sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			stop_test();
		end
	end
	// ****
	// Tasks
	// ****
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] exp);
		notes.push_back({w, exp});
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_rel();
		n = 0;
		while (cpu_clock_release !== 1'b1) begin
			@(posedge sys_clk);
			n++;
		end
	endtask
	task automatic wake_green();
		timer_wake <= 1'b1;
		@(posedge sys_clk);
		timer_wake <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("release", cpu_clock_release, 1);
	endtask
	always @(posedge sys_clk) begin
		if (psel && penable && pready === 1'b1) begin
			note = notes.pop_front();
			chk("pslverr", pslverr, note[32]);
			if (!note[33]) chk("prdata", prdata, note[31:0]);
		end
	end
	// ****
	// Main sequence
	// ****
	initial begin
		for (int o = 0; o < 6; o++) begin
			r = rnd();
			reset_n <= 1'b0;
			high_clock_option <= 3'(o);
			fcpu_divide_code <= r[2:0];
			watchdog_always_on <= r[3];
			watchdog_enable <= r[3];
			repeat (4) @(posedge sys_clk);
			chk("rst_slow_rc", internal_slow_rc_osc_enable, 1);
			chk("rst_release", cpu_clock_release, 0);
			reset_n <= 1'b1;
			wait_rel();
			chk("warm_up", n > 8188 && n < 8300, 1);
			c = (r[2:0] > 4) ? 4 : r[2:0];
			if (o < 2 && c < 2) c = 2;
			chk("divide", fcpu_divide_log2, c);
			chk("in_gpio", crystal_in_pin_gpio, o == 0);
			chk("out_gpio", crystal_out_pin_gpio, o == 0 || o == 2);
			chk("rtc_en", rtc_crystal_enable, o == 1);
			chk("fast_en", internal_fast_rc_osc_enable, o < 2);
			chk("ext_en", external_osc_enable, o >= 2);
			if (o == 0) begin
				apb(0, 12'h328, 0, 33'h0);
				apb(1, 12'h328, {r[31:5], 5'h04}, 33'h0);
				repeat (4) @(posedge sys_clk);
				chk("slow", system_clock_slow, 1);
				chk("slow_div", fcpu_divide_log2, 2);
				chk("fast_kept", internal_fast_rc_osc_enable, 1);
				apb(1, 12'h328, 32'h6, 33'h0);
				repeat (4) @(posedge sys_clk);
				chk("fast_stop", internal_fast_rc_osc_enable, 0);
				chk("slow_rc", internal_slow_rc_osc_enable, 1);
				apb(0, 12'h328, 0, 33'h6);
				apb(1, 12'h328, 32'h16, 33'h0);
				repeat (4) @(posedge sys_clk);
				chk("green", cpu_clock_release, 0);
				chk("green_fast", internal_fast_rc_osc_enable, 0);
				wake_green();
				apb(0, 12'h328, 0, 33'h6);
				apb(1, 12'h328, 32'hC, 33'h0);
				repeat (4) @(posedge sys_clk);
				chk("sleep_rc", internal_slow_rc_osc_enable, 0);
				port_wake <= !port_wake;
				wait_rel();
				chk("wake_warm", n > 124 && n < 200, 1);
				chk("wake_normal", system_clock_slow, 0);
				apb(0, 12'h328, 0, 33'h0);
				apb(0, 12'h32C, 0, 33'h49);
				apb(0, 12'h400, 0, {1'b1, 32'h0});
				apb(1, 12'h32C, rnd(), {1'b1, 32'h0});
			end
			if (o == 1) begin
				apb(1, 12'h328, 32'h10, 33'h0);
				repeat (4) @(posedge sys_clk);
				chk("green_rc", internal_slow_rc_osc_enable, watchdog_always_on);
				chk("green_rtc", rtc_crystal_enable, 1);
				chk("green_fast", internal_fast_rc_osc_enable, 1);
				wake_green();
			end
			$display("test option %0d done", o);
		end
		stop_test();
	end
endmodule
bind oscillator_mode_control osc_mode_asserts u_osc_mode_asserts (.*);
`default_nettype wire
